// ==== rtl/tmr_defines.svh ====
// Register map, field positions, reset values and sync counts of the timer block.
// Assumes inclusion by its bare name from any file that needs these constants.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------
// Register indices (word address)
// ----------------------------------------
`define TMR_ADDR_W        3
`define TMR_DATA_W        16
`define TMR_ADR_CTRL      3'h0
`define TMR_ADR_MODE      3'h1
`define TMR_ADR_COUNT     3'h2
`define TMR_ADR_IRQ       3'h3
`define TMR_ADR_CAPT      3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMR_B_START       0
`define TMR_B_ACTIVE      4
`define TMR_B_EDGE        5
`define TMR_B_UDF         6
`define TMR_B_IRQ         0

// ----------------------------------------
// Reset values and sync depths
// ----------------------------------------
`define TMR_RST_COUNT     16'hffff
`define TMR_SYNC_EDGES    3'h3

`endif

// ==== rtl/tmr_pkg.sv ====
// Types shared by the timer block: operating modes, sync states, control fields.
// Assumes tmr_defines.svh is on the include path.
package tmr_pkg;

   typedef enum logic [1:0] {
      TMR_MODE_TIMER  = 2'h0,
      TMR_MODE_EVENT  = 2'h1,
      TMR_MODE_PWIDTH = 2'h2,
      TMR_MODE_PPER   = 2'h3
   } tmr_mode_t;

   // One-hot start/stop synchroniser states
   typedef enum logic [5:0] {
      TMR_ST_STOP   = 6'h01,
      TMR_ST_ARM    = 6'h02,
      TMR_ST_ARM2   = 6'h04,
      TMR_ST_RUN    = 6'h08,
      TMR_ST_HALT   = 6'h10,
      TMR_ST_HALT2  = 6'h20
   } tmr_state_t;

   typedef struct packed {
      logic start;
      logic edge_clr;
      logic udf_clr;
   } tmr_ctrl_wr_t;

endpackage

// ==== rtl/tmr_pin_sync.sv ====
// Two-stage synchronisers with rising and falling edge detect for external pins.
// Assumes pins are asynchronous to i_clk; outputs are i_clk-domain.
`timescale 1ns/10ps
module tmr_pin_sync #(
   parameter int W = 2
) (
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               meta_r[g] <= 1'b0;
               sync_r[g] <= 1'b0;
               prev_r[g] <= 1'b0;
            end else begin
               meta_r[g] <= i_pin[g];
               sync_r[g] <= meta_r[g];
               prev_r[g] <= sync_r[g];
            end
         end
         assign o_level[g] = sync_r[g];
         assign o_rise[g]  = sync_r[g] & ~prev_r[g];
         assign o_fall[g]  = ~sync_r[g] & prev_r[g];
      end
   endgenerate

endmodule

// ==== rtl/tmr_timer.sv ====
// Down-counting timer with start/stop handshake, edge and underflow flags.
// Assumes a plain register port on i_clk; count source and event pin are async pins.
`timescale 1ns/10ps
`include "tmr_defines.svh"

// What this block does
// - After reset the timer is stopped and waits for software to start it.
// - After start, active status reads 0 for two to three source cycles.
// - Counting begins at the first count edge after active status becomes 1 (event pin rise in event mode).
// - After stop, active status stays 1 two to three cycles; count halts then.
// - Pulse modes set the edge flag on edges; underflow sets the underflow flag.
// - Edge and underflow flags clear only on writing 0; writing 1 keeps them.
// - Edge flag reads 0 at once; internal state stays 1 one-two cycles.
// - An edge during that hold keeps the state set and reads back 1.
// - Request flag sets only on a 0-to-1 change of the internal edge state.
module tmr_timer
   import tmr_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   input  wire logic [`TMR_ADDR_W-1:0] i_addr,
   input  wire logic [`TMR_DATA_W-1:0] i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   input  wire logic                   i_cnt_src,
   input  wire logic                   i_evt_pin,
   output logic      [`TMR_DATA_W-1:0] o_rdata,
   output logic                        o_count_active,
   output logic                        o_irq_flag
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] pin_lvl;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;

   tmr_pin_sync #(.W(2)) u_sync (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_pin   ({i_evt_pin, i_cnt_src}),
      .o_level (pin_lvl),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   wire src_edge = pin_rise[0];

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   function automatic logic hit(input logic [`TMR_ADDR_W-1:0] a,
                                input logic [`TMR_ADDR_W-1:0] r);
      return a == r;
   endfunction

   wire ctl_wr  = i_wr & hit(i_addr, `TMR_ADR_CTRL);
   wire mode_wr = i_wr & hit(i_addr, `TMR_ADR_MODE);
   wire cnt_wr  = i_wr & hit(i_addr, `TMR_ADR_COUNT);
   wire irq_wr  = i_wr & hit(i_addr, `TMR_ADR_IRQ);

   tmr_ctrl_wr_t cw;
   assign cw.start    = i_wdata[`TMR_B_START];
   assign cw.edge_clr = ctl_wr & ~i_wdata[`TMR_B_EDGE];
   assign cw.udf_clr  = ctl_wr & ~i_wdata[`TMR_B_UDF];

   logic                   start_req_r;
   tmr_mode_t              mode_r;
   logic [`TMR_DATA_W-1:0] cnt_r;
   logic [`TMR_DATA_W-1:0] reload_r;
   logic [`TMR_DATA_W-1:0] capt_r;
   tmr_state_t             st_r;
   tmr_state_t             st_nxt;
   logic                   stat_r;
   logic                   edge_int_r;
   logic                   edge_pend_r;
   logic                   clr_pend_r;
   logic                   clr_step_r;
   logic                   udf_r;
   logic                   irq_r;
   logic [`TMR_DATA_W-1:0] rdata_nxt;

   // ----------------------------------------
   // Start/stop handshake on source edges
   // ----------------------------------------
   // Status flips on the third source edge after the request changes, so the
   // old value stands two to three source cycles whatever the write phase.
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         TMR_ST_STOP:  if (start_req_r) st_nxt = TMR_ST_ARM;
         TMR_ST_ARM:   st_nxt = start_req_r ? TMR_ST_ARM2 : TMR_ST_STOP;
         TMR_ST_ARM2:  st_nxt = start_req_r ? TMR_ST_RUN : TMR_ST_STOP;
         TMR_ST_RUN:   if (!start_req_r) st_nxt = TMR_ST_HALT;
         TMR_ST_HALT:  st_nxt = start_req_r ? TMR_ST_RUN : TMR_ST_HALT2;
         TMR_ST_HALT2: st_nxt = start_req_r ? TMR_ST_RUN : TMR_ST_STOP;
         default:      st_nxt = TMR_ST_STOP;
      endcase
   end

   wire stat_nxt = (st_nxt == TMR_ST_RUN) | (st_nxt == TMR_ST_HALT) |
                   (st_nxt == TMR_ST_HALT2);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r   <= TMR_ST_STOP;
         stat_r <= 1'b0;
      end else if (src_edge) begin
         st_r   <= st_nxt;
         stat_r <= stat_nxt;
      end
   end

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   wire mode_meas = (mode_r == TMR_MODE_PWIDTH) | (mode_r == TMR_MODE_PPER);
   wire cnt_edge  = (mode_r == TMR_MODE_EVENT)  ? pin_rise[1] :
                    (mode_r == TMR_MODE_PWIDTH) ? (src_edge & pin_lvl[1]) : src_edge;
   wire cnt_en    = stat_r & cnt_edge;
   wire udf_evt   = cnt_en & (cnt_r == '0);
   wire meas_edge = mode_meas & stat_r &
                    ((mode_r == TMR_MODE_PWIDTH) ? pin_fall[1] : pin_rise[1]);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         start_req_r <= 1'b0;
         mode_r      <= TMR_MODE_TIMER;
         cnt_r       <= `TMR_RST_COUNT;
         reload_r    <= `TMR_RST_COUNT;
         capt_r      <= '0;
      end else begin
         if (ctl_wr)
            start_req_r <= cw.start;
         if (mode_wr)
            mode_r <= tmr_mode_t'(i_wdata[1:0]);
         if (cnt_wr) begin
            cnt_r    <= i_wdata;
            reload_r <= i_wdata;
         end else if (udf_evt)
            cnt_r <= reload_r;
         else if (cnt_en)
            cnt_r <= cnt_r - 16'h0001;
         if (meas_edge)
            capt_r <= cnt_r;
      end
   end

   // ----------------------------------------
   // Edge, underflow and request flags
   // ----------------------------------------
   // The clear of the edge state lands two source edges late so that an edge
   // caught in flight is never dropped; the read value hides the pending clear.
   wire edge_rd    = edge_int_r & ~clr_pend_r;
   wire take_edge  = src_edge & edge_pend_r;
   wire edge_int_n = take_edge ? 1'b1 : (src_edge & clr_step_r) ? 1'b0 : edge_int_r;
   wire irq_set    = edge_int_n & ~edge_int_r;
   wire udf_set    = udf_evt & stat_r;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         edge_int_r  <= 1'b0;
         edge_pend_r <= 1'b0;
         clr_pend_r  <= 1'b0;
         clr_step_r  <= 1'b0;
         udf_r       <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         edge_int_r  <= edge_int_n;
         edge_pend_r <= meas_edge | (edge_pend_r & ~src_edge);
         if (take_edge) begin
            clr_pend_r <= 1'b0;
            clr_step_r <= 1'b0;
         end else if (src_edge & clr_step_r) begin
            clr_pend_r <= 1'b0;
            clr_step_r <= 1'b0;
         end else begin
            clr_pend_r <= clr_pend_r | (cw.edge_clr & edge_int_r);
            clr_step_r <= clr_step_r | (src_edge & clr_pend_r);
         end
         udf_r <= udf_set | (udf_r & ~cw.udf_clr);
         irq_r <= irq_set | (irq_r & ~(irq_wr & ~i_wdata[`TMR_B_IRQ]));
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      rdata_nxt = '0;
      if (i_rd) begin
         case (i_addr)
            `TMR_ADR_CTRL: begin
               rdata_nxt[`TMR_B_START]  = start_req_r;
               rdata_nxt[`TMR_B_ACTIVE] = stat_r;
               rdata_nxt[`TMR_B_EDGE]   = edge_rd;
               rdata_nxt[`TMR_B_UDF]    = udf_r;
            end
            `TMR_ADR_MODE:  rdata_nxt[1:0] = mode_r;
            `TMR_ADR_COUNT: rdata_nxt = cnt_r;
            `TMR_ADR_IRQ:   rdata_nxt[`TMR_B_IRQ] = irq_r;
            `TMR_ADR_CAPT:  rdata_nxt = capt_r;
            default:        rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end

   assign o_count_active = stat_r;
   assign o_irq_flag     = irq_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Source edges seen since the start request last changed, saturating
   logic [2:0] edges_r;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         edges_r <= 3'h0;
      end else if (ctl_wr & (cw.start != start_req_r)) begin
         edges_r <= 3'h0;
      end else if (src_edge & (edges_r != 3'h7)) begin
         edges_r <= edges_r + 3'h1;
      end
   end

   sequence s_clear_edge;
      cw.edge_clr && edge_int_r && !take_edge;
   endsequence

   a_stop_holds: assert property (!start_req_r && !stat_r && st_r == TMR_ST_STOP |=> !stat_r)
      else $error("timer left stop without request");
   a_start_delay: assert property ($rose(stat_r) |-> edges_r == `TMR_SYNC_EDGES)
      else $error("active status rose at wrong source edge");
   a_stop_delay: assert property ($fell(stat_r) |-> edges_r == `TMR_SYNC_EDGES)
      else $error("active status fell at wrong source edge");
   a_count_gated: assert property (cnt_r != $past(cnt_r) |-> $past(cnt_wr) || $past(cnt_en))
      else $error("counter moved while not active");
   a_udf_sets: assert property (udf_set |=> udf_r)
      else $error("underflow flag not set");
   a_udf_keep: assert property (ctl_wr && i_wdata[`TMR_B_UDF] && udf_r |=> udf_r)
      else $error("writing one cleared underflow flag");
   a_udf_clear: assert property (cw.udf_clr && !udf_set |=> !udf_r)
      else $error("writing zero left underflow flag set");
   a_edge_read_zero: assert property (s_clear_edge |=> !edge_rd)
      else $error("edge flag not read as zero after clear");
   a_edge_int_hold: assert property (s_clear_edge |=> edge_int_r)
      else $error("internal edge state dropped too soon");
   a_edge_rearm: assert property (take_edge && clr_pend_r |=> edge_int_r && edge_rd)
      else $error("edge during clear hold lost");
   a_irq_on_rise: assert property ($rose(irq_r) |-> $rose(edge_int_r))
      else $error("request flag set without edge state rise");
   a_irq_follows: assert property ($rose(edge_int_r) |-> irq_r)
      else $error("edge state rose without request flag");

endmodule

// ==== sim/tmr_pulse_src.sv ====
// Far-side model: a free-running count source and an event pin pulsed on demand.
// Assumes the timer samples both pins through its own synchronisers.
`timescale 1ns/10ps
module tmr_pulse_src #(
   parameter int HALF_NS = 200
) (
   output logic o_cnt_src,
   output logic o_evt_pin
);
   // ----------------------------------------
   // Count source and event pin
   // ----------------------------------------
   // Phase offset keeps source edges away from system clock edges
   initial begin
      o_cnt_src = 1'b0;
      o_evt_pin = 1'b0;
      #7;
      forever begin
         #(HALF_NS) o_cnt_src = ~o_cnt_src;
      end
   end

   // Wide enough to pass the two-stage pin synchroniser
   task automatic pulse();
      o_evt_pin = 1'b1;
      #160;
      o_evt_pin = 1'b0;
      #160;
   endtask
endmodule

// ==== sim/test_tmr_timer.sv ====
// Self-checking bench for the timer: register bus, start/stop handshake, flags.
// Assumes tmr_pulse_src drives the count source and the event pin.
`timescale 1ns/10ps
`include "tmr_defines.svh"
module test_tmr_timer
   import tmr_pkg::*;
;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   logic        i_clk   = 1'b0;
   logic        i_nrst  = 1'b0;
   logic [2:0]  i_addr  = 3'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr    = 1'b0;
   logic        i_rd    = 1'b0;
   wire         cnt_src;
   wire         evt_pin;
   logic [15:0] o_rdata;
   logic        o_count_active;
   logic        o_irq_flag;
   logic [15:0] rd_val;
   int          bad_count = 0;
   int          checks    = 0;

   always #20 i_clk = ~i_clk;

   tmr_timer i_tmr_timer (
      .i_clk          (i_clk),
      .i_nrst         (i_nrst),
      .i_addr         (i_addr),
      .i_wdata        (i_wdata),
      .i_wr           (i_wr),
      .i_rd           (i_rd),
      .i_cnt_src      (cnt_src),
      .i_evt_pin      (evt_pin),
      .o_rdata        (o_rdata),
      .o_count_active (o_count_active),
      .o_irq_flag     (o_irq_flag)
   );

   tmr_pulse_src i_tmr_pulse_src (
      .o_cnt_src (cnt_src),
      .o_evt_pin (evt_pin)
   );

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      rd_val = o_rdata;
   endtask

   // Source pin edges plus the synchroniser delay inside the timer
   task automatic src(input int n);
      repeat (n) @(posedge cnt_src);
      repeat (5) @(posedge i_clk);
      #1;
   endtask

   // Puts the next write just after the timer has taken a source edge
   task automatic align();
      @(posedge cnt_src);
      repeat (3) @(posedge i_clk);
   endtask

   function automatic logic [15:0] act();
      return {15'h0000, o_count_active};
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rd(`TMR_ADR_CTRL);
      chk(rd_val, 16'h0000, "ctrl after reset");
      src(4);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, `TMR_RST_COUNT, "count moved");
      @(posedge i_clk);
      #1;
      chk(o_rdata, 16'h0000, "read data held over");
      chk(act(), 16'h0000, "active after reset");
      wr(3'h5, 16'h1234);
      rd(3'h5);
      chk(rd_val, 16'h0000, "unmapped read");
      wr(`TMR_ADR_CTRL, 16'h0010);
      rd(`TMR_ADR_CTRL);
      chk(rd_val, 16'h0000, "active bit writable");
      wr(`TMR_ADR_COUNT, 16'h00a5);
      repeat (2) @(posedge i_clk);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, 16'h00a5, "count load while stopped");
   endtask

   task automatic t_start_stop();
      logic [15:0] held;
      wr(`TMR_ADR_COUNT, 16'h0010);
      align();
      wr(`TMR_ADR_CTRL, 16'h0061);
      src(1);
      chk(act(), 16'h0000, "active too early");
      src(1);
      chk(act(), 16'h0000, "active after two edges");
      src(1);
      chk(act(), 16'h0001, "active too late");
      rd(`TMR_ADR_COUNT);
      chk(rd_val, 16'h0010, "count before edge");
      src(1);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, 16'h000f, "first decrement");
      wr(`TMR_ADR_COUNT, 16'h0030);
      src(4);
      wr(`TMR_ADR_COUNT, 16'h0020);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, 16'h0020, "reload while running");
      align();
      wr(`TMR_ADR_CTRL, 16'h0060);
      src(1);
      chk(act(), 16'h0001, "stopped too early");
      src(1);
      chk(act(), 16'h0001, "stopped after two edges");
      src(1);
      chk(act(), 16'h0000, "still active");
      rd(`TMR_ADR_COUNT);
      held = rd_val;
      src(2);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, held, "count moved when stopped");
   endtask

   task automatic t_underflow();
      wr(`TMR_ADR_COUNT, 16'h0002);
      align();
      wr(`TMR_ADR_CTRL, 16'h0061);
      src(6);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0050, 16'h0050, "underflow flag");
      align();
      wr(`TMR_ADR_CTRL, 16'h0060);
      src(3);
      wr(`TMR_ADR_CTRL, 16'h0040);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0040, 16'h0040, "flag lost on 1");
      wr(`TMR_ADR_CTRL, 16'h0000);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0040, 16'h0000, "flag kept on 0");
   endtask

   task automatic t_event();
      wr(`TMR_ADR_MODE, {14'h0000, TMR_MODE_EVENT});
      wr(`TMR_ADR_COUNT, 16'h0100);
      align();
      wr(`TMR_ADR_CTRL, 16'h0001);
      src(3);
      repeat (3) i_tmr_pulse_src.pulse();
      rd(`TMR_ADR_COUNT);
      chk(rd_val, 16'h00fd, "event count");
      align();
      wr(`TMR_ADR_CTRL, 16'h0000);
      src(3);
   endtask

   task automatic t_edge();
      wr(`TMR_ADR_MODE, {14'h0000, TMR_MODE_PPER});
      wr(`TMR_ADR_COUNT, 16'hffff);
      align();
      wr(`TMR_ADR_CTRL, 16'h0061);
      src(3);
      i_tmr_pulse_src.pulse();
      src(2);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0020, "edge flag");
      chk({15'h0000, o_irq_flag}, 16'h0001, "irq on edge");
      wr(`TMR_ADR_IRQ, 16'h0000);
      rd(`TMR_ADR_IRQ);
      chk(rd_val, 16'h0000, "irq not cleared");
      align();
      wr(`TMR_ADR_CTRL, 16'h0041);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0000, "edge read after clear");
      i_tmr_pulse_src.pulse();
      src(3);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0020, "edge not kept");
      chk({15'h0000, o_irq_flag}, 16'h0000, "irq on held state");
      wr(`TMR_ADR_CTRL, 16'h0041);
      src(3);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0000, "edge not cleared");
      i_tmr_pulse_src.pulse();
      src(2);
      chk({15'h0000, o_irq_flag}, 16'h0001, "irq on fresh edge");
   endtask

   // Pulse width mode: count only while the pin is high, measure on its fall
   task automatic t_width();
      logic [15:0] held;
      wr(`TMR_ADR_IRQ, 16'h0000);
      wr(`TMR_ADR_CTRL, 16'h0041);
      wr(`TMR_ADR_MODE, {14'h0000, TMR_MODE_PWIDTH});
      rd(`TMR_ADR_MODE);
      chk(rd_val, 16'h0002, "mode readback");
      src(3);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0000, "width edge cleared");
      rd(`TMR_ADR_COUNT);
      held = rd_val;
      src(2);
      rd(`TMR_ADR_COUNT);
      chk(rd_val, held, "count moved with pin low");
      i_tmr_pulse_src.pulse();
      src(2);
      rd(`TMR_ADR_CTRL);
      chk(rd_val & 16'h0020, 16'h0020, "edge flag on falling edge");
      chk({15'h0000, o_irq_flag}, 16'h0001, "irq on width edge");
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_reset();
      t_start_stop();
      t_underflow();
      t_event();
      t_edge();
      t_width();
      give_verdict();
   end

   // Whole sequence needs well under a tenth of this span
   initial begin
      #2000000;
      bad_count++;
      $display("BAD at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
